// [design/smbpc_bus_cond.sv]
module smbpc_bus_cond
    import smbpc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);

    logic scl_q_reg;
    logic sda_q_reg;

    // previous line levels; idle bus is high on both
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl;
            sda_q_reg <= sda;
        end
    end

    // data edges while the clock is high frame a transaction
    assign scl_rise  = scl & ~scl_q_reg;
    assign scl_fall  = ~scl & scl_q_reg;
    assign start_det = scl & scl_q_reg & sda_q_reg & ~sda;
    assign stop_det  = scl & scl_q_reg & ~sda_q_reg & sda;

endmodule

// [design/smbpc_pkg.sv]
package smbpc_pkg;

    // clock rate, used to turn times into cycle counts
    localparam int CLK_MHZ = 25;

    // bus address: fixed high nibble, then a zero, then the select pin
    localparam logic [3:0] BUS_ID_HI  = 4'hA;
    localparam logic       BUS_ID_FIX = 1'b0;

    // command bytes outside the pointer space
    localparam logic [7:0] CMD_BLK_WR = 8'hC0;
    localparam logic [7:0] CMD_BLK_RD = 8'hC1;
    localparam logic [7:0] CMD_REBOOT = 8'hC4;

    // pointer regions
    localparam logic [7:0] CFG_LAST   = 8'h2F;
    localparam logic [7:0] USER_FIRST = 8'h40;
    localparam logic [7:0] CEE_FIRST  = 8'h80;
    localparam logic [7:0] CEE_LAST   = 8'h9F;
    localparam int         MEM_WORDS  = 160;

    // block transfer figures
    localparam logic [7:0] BLK_RD_COUNT = 8'h10;
    localparam logic [4:0] BLK_MAX      = 5'h10;
    localparam logic [4:0] BLK_MIN      = 5'h01;
    localparam logic [3:0] BYTE_BITS    = 4'h8;

    // configuration latency: under 5 us, thresholds typically 150 us
    localparam int EFFECT_FAST_NS = 5000;
    localparam int EFFECT_THR_NS  = 150000;
    localparam logic [11:0] EFFECT_FAST_CYC = 12'(EFFECT_FAST_NS * CLK_MHZ / 1000 - 1);
    localparam logic [11:0] EFFECT_THR_CYC  = 12'(EFFECT_THR_NS * CLK_MHZ / 1000);
    localparam logic [11:0] CNT_ONE         = 12'h001;

    typedef enum logic [6:0] {
        PH_IDLE    = 7'h01,
        PH_ADDR    = 7'h02,
        PH_ACK_OUT = 7'h04,
        PH_RX      = 7'h08,
        PH_TX      = 7'h10,
        PH_ACK_IN  = 7'h20,
        PH_HOLD    = 7'h40
    } smbpc_phase_t;

    typedef enum logic [2:0] {
        LD_WAIT  = 3'h1,
        LD_COPY  = 3'h2,
        LD_READY = 3'h4
    } smbpc_load_t;

    typedef enum logic [2:0] {
        WM_NONE  = 3'h1,
        WM_BYTE  = 3'h2,
        WM_BLOCK = 3'h4
    } smbpc_wmode_t;

    // pointer may address configuration registers or either EEPROM
    function automatic logic ptr_legal(input logic [7:0] p);
        ptr_legal = (p <= CFG_LAST) || (p >= USER_FIRST && p <= CEE_LAST);
    endfunction

    // step the pointer, holding at the two region tops; user top runs on
    function automatic logic [7:0] ptr_advance(input logic [7:0] p);
        ptr_advance = (p == CFG_LAST || p == CEE_LAST) ? p : p + 8'h01;
    endfunction

endpackage

// [design/smbpc_serial_core.sv]
// Contract
// - pointer steps after each read, except boundaries
// - busy or illegal command gets NACK, pointer kept
// - block read returns up to sixteen bytes
// - early STOP or NACK ends read, line released
// - command C1h starts block read unless busy
// - read phase sends count sixteen then data
// - 00h-2Fh configuration registers, others outside NACKed
// - configuration block write saturates at read-only 2Fh
// - 80h-9Fh select configuration EEPROM
// - configuration EEPROM write saturates, last byte kept
// - 40h-7Fh user EEPROM, block access allowed
// - pointer runs from 7Fh into 80h
// - above 1V outputs forced low until loaded
// - above lockout, copy configuration EEPROM quickly
// - after load outputs follow loaded configuration
// - before load every access is NACKed
// - register writes act within 5us, thresholds 150us
// - EEPROM changes reach registers only on reload
// - command C4h reboots and reloads configuration
// - NACK command during reboot, EEPROM write, bad address
// - address 1010, zero, select pin, don't-care, direction
// - command C0h block write, count first, 1-16
module smbpc_serial_core
    import smbpc_pkg::*;
#(
    parameter int         EE_WR_CYCLES     = 1000,
    parameter logic [7:0] THRESH_LAST_ADDR = 8'h0B
)(
    input  wire logic  CLK,
    input  wire logic  RST,
    input  wire logic  SCL,
    input  wire logic  SDA_IN,
    output logic       SDA_OUT,
    output logic       SDA_OE,
    input  wire logic  ADDRESS_SELECT_PIN,
    input  wire logic  SUPPLY_ABOVE_1V,
    input  wire logic  SUPPLY_ABOVE_LOCKOUT_LEVEL,
    output logic       OUTPUTS_FORCED_LOW,
    output logic       CONFIG_LOADED,
    output logic       BUSY,
    output logic       CFG_APPLY_STB,
    output logic [7:0] CFG_APPLY_ADDR,
    output logic [7:0] CFG_APPLY_DATA
);

    logic         scl_rise;
    logic         scl_fall;
    logic         start_det;
    logic         stop_det;
    smbpc_phase_t ph_reg;
    smbpc_load_t  ld_reg;
    smbpc_wmode_t wm_reg;
    logic [7:0]   shift_reg;
    logic [7:0]   ptr_reg;
    logic [7:0]   copy_idx_reg;
    logic [3:0]   bit_reg;
    logic [1:0]   rx_idx_reg;
    logic [4:0]   blk_cnt_reg;
    logic [4:0]   bw_left_reg;
    logic [15:0]  ee_cnt_reg;
    logic [11:0]  eff_cnt_reg;
    logic [7:0]   pend_addr_reg;
    logic         pend_reg;
    logic         rw_reg;
    logic         sda_oe_reg;
    logic         acked_reg;
    logic         blk_armed_reg;
    logic         blk_active_reg;
    logic         reboot_req_reg;
    logic         ee_wrote_reg;
    logic         forced_reg;
    logic [7:0]   mem [0:MEM_WORDS-1];
    logic         busy;
    logic         loaded;
    logic         byte_done;
    logic         addr_eval;
    logic         cmd_eval;
    logic         data_eval;
    logic         addr_match;
    logic         ack_cmd;
    logic         ack_data;
    logic         wr_evt;
    logic         cfg_wr;
    logic         ld_data;
    logic         blk_end;

    smbpc_bus_cond u_cond (
        .clk       (CLK),
        .rst       (RST),
        .scl       (SCL),
        .sda       (SDA_IN),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // one busy term covers load, reboot and EEPROM programming
    assign loaded    = (ld_reg == LD_READY);
    assign busy      = !loaded || (ee_cnt_reg != 16'h0000);
    assign byte_done = scl_fall && (bit_reg == BYTE_BITS);
    assign addr_eval = (ph_reg == PH_ADDR) && byte_done;
    assign cmd_eval  = (ph_reg == PH_RX) && byte_done && (rx_idx_reg == 2'h0);
    assign data_eval = (ph_reg == PH_RX) && byte_done && (rx_idx_reg != 2'h0);
    assign blk_end   = blk_active_reg && (blk_cnt_reg == BLK_MAX);

    // the don't-care bit is shift_reg[1]
    assign addr_match = (shift_reg[7:4] == BUS_ID_HI) && (shift_reg[3] == BUS_ID_FIX)
                        && (shift_reg[2] == ADDRESS_SELECT_PIN);

    // command byte acceptance
    assign ack_cmd = !busy && (shift_reg == CMD_BLK_WR || shift_reg == CMD_BLK_RD
                     || shift_reg == CMD_REBOOT || ptr_legal(shift_reg));

    // data byte acceptance: count byte checked, surplus block bytes refused
    always_comb begin
        ack_data = 1'b0;
        unique case (wm_reg)
            WM_NONE:  ack_data = 1'b0;
            WM_BYTE:  ack_data = 1'b1;
            WM_BLOCK: ack_data = (rx_idx_reg == 2'h1)
                                 ? (shift_reg[7:5] == 3'h0 && shift_reg[4:0] >= BLK_MIN
                                    && shift_reg[4:0] <= BLK_MAX)
                                 : (bw_left_reg != 5'h00);
        endcase
    end

    assign wr_evt  = data_eval && ack_data && !(wm_reg == WM_BLOCK && rx_idx_reg == 2'h1);
    assign cfg_wr  = wr_evt && (ptr_reg < CFG_LAST);
    assign ld_data = scl_fall && (((ph_reg == PH_ACK_IN) && acked_reg && !blk_end)
                     || ((ph_reg == PH_ACK_OUT) && rw_reg && !blk_armed_reg));

    // pointer: preset by command, stepped by every read or write
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ptr_reg <= 8'h00;
        end else if (cmd_eval && ack_cmd && ptr_legal(shift_reg)) begin
            ptr_reg <= shift_reg;
        end else if (ld_data || wr_evt) begin
            ptr_reg <= ptr_advance(ptr_reg);
        end
    end

    // bus protocol engine
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ph_reg         <= PH_IDLE;
            wm_reg         <= WM_NONE;
            shift_reg      <= 8'h00;
            bit_reg        <= 4'h0;
            rx_idx_reg     <= 2'h0;
            blk_cnt_reg    <= 5'h00;
            bw_left_reg    <= 5'h00;
            rw_reg         <= 1'b0;
            sda_oe_reg     <= 1'b0;
            acked_reg      <= 1'b0;
            blk_armed_reg  <= 1'b0;
            blk_active_reg <= 1'b0;
            reboot_req_reg <= 1'b0;
            ee_wrote_reg   <= 1'b0;
        end else if (start_det) begin
            // repeated start keeps an armed block read alive
            ph_reg     <= PH_ADDR;
            bit_reg    <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else if (stop_det) begin
            ph_reg         <= PH_IDLE;
            wm_reg         <= WM_NONE;
            sda_oe_reg     <= 1'b0;
            blk_armed_reg  <= 1'b0;
            blk_active_reg <= 1'b0;
            reboot_req_reg <= 1'b0;
            ee_wrote_reg   <= 1'b0;
        end else begin
            unique case (ph_reg)
                PH_IDLE, PH_HOLD: begin
                    sda_oe_reg <= 1'b0;
                end
                PH_ADDR, PH_RX: begin
                    if (scl_rise && bit_reg != BYTE_BITS) begin
                        shift_reg <= {shift_reg[6:0], SDA_IN};
                        bit_reg   <= bit_reg + 4'h1;
                    end
                    if (addr_eval) begin
                        rw_reg        <= shift_reg[0];
                        rx_idx_reg    <= 2'h0;
                        blk_armed_reg <= blk_armed_reg && shift_reg[0];
                        sda_oe_reg    <= addr_match && loaded;
                        ph_reg        <= (addr_match && loaded) ? PH_ACK_OUT : PH_HOLD;
                    end else if (cmd_eval) begin
                        // refused command leaves pointer, write mode and request flags as they were
                        sda_oe_reg <= ack_cmd;
                        ph_reg     <= ack_cmd ? PH_ACK_OUT : PH_HOLD;
                        rx_idx_reg <= 2'h1;
                        if (ack_cmd) begin
                            wm_reg         <= (shift_reg == CMD_BLK_WR) ? WM_BLOCK
                                              : ptr_legal(shift_reg) ? WM_BYTE : WM_NONE;
                            blk_armed_reg  <= (shift_reg == CMD_BLK_RD);
                            reboot_req_reg <= (shift_reg == CMD_REBOOT);
                        end
                    end else if (data_eval) begin
                        sda_oe_reg <= ack_data;
                        ph_reg     <= ack_data ? PH_ACK_OUT : PH_HOLD;
                        rx_idx_reg <= 2'h2;
                        if (wm_reg == WM_BLOCK && rx_idx_reg == 2'h1) begin
                            bw_left_reg <= shift_reg[4:0];
                        end else if (wr_evt) begin
                            bw_left_reg  <= bw_left_reg - 5'h01;
                            ee_wrote_reg <= ee_wrote_reg || (ptr_reg >= USER_FIRST);
                        end
                    end
                end
                PH_ACK_OUT: begin
                    if (scl_fall) begin
                        bit_reg <= 4'h0;
                        ph_reg  <= PH_RX;
                        sda_oe_reg <= 1'b0;
                        if (rw_reg && blk_armed_reg) begin
                            // block read opens with its byte count
                            shift_reg      <= BLK_RD_COUNT;
                            sda_oe_reg     <= ~BLK_RD_COUNT[7];
                            blk_active_reg <= 1'b1;
                            blk_armed_reg  <= 1'b0;
                            blk_cnt_reg    <= 5'h00;
                            bit_reg        <= 4'h1;
                            ph_reg         <= PH_TX;
                        end else if (rw_reg) begin
                            shift_reg  <= mem[ptr_reg];
                            sda_oe_reg <= ~mem[ptr_reg][7];
                            bit_reg    <= 4'h1;
                            ph_reg     <= PH_TX;
                        end
                    end
                end
                PH_TX: begin
                    if (scl_fall && bit_reg == BYTE_BITS) begin
                        sda_oe_reg <= 1'b0;
                        acked_reg  <= 1'b0;
                        ph_reg     <= PH_ACK_IN;
                    end else if (scl_fall) begin
                        sda_oe_reg <= ~shift_reg[6];
                        shift_reg  <= {shift_reg[6:0], 1'b0};
                        bit_reg    <= bit_reg + 4'h1;
                    end
                end
                PH_ACK_IN: begin
                    if (scl_rise) begin
                        acked_reg <= !SDA_IN;
                        if (SDA_IN) begin
                            ph_reg <= PH_HOLD;
                        end
                    end else if (scl_fall && acked_reg && blk_end) begin
                        ph_reg <= PH_HOLD;
                    end else if (ld_data) begin
                        shift_reg   <= mem[ptr_reg];
                        sda_oe_reg  <= ~mem[ptr_reg][7];
                        bit_reg     <= 4'h1;
                        ph_reg      <= PH_TX;
                        blk_cnt_reg <= blk_cnt_reg + {4'h0, blk_active_reg};
                    end
                end
            endcase
        end
    end

    // memory: 2Fh is read-only; EEPROM writes never touch live registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < MEM_WORDS; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (ld_reg == LD_COPY) begin
            mem[copy_idx_reg] <= mem[CEE_FIRST + copy_idx_reg];
        end else if (wr_evt && ptr_reg != CFG_LAST) begin
            mem[ptr_reg] <= shift_reg;
        end
    end

    // power-up and reboot download, one byte per clock
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ld_reg       <= LD_WAIT;
            copy_idx_reg <= 8'h00;
        end else if (!SUPPLY_ABOVE_LOCKOUT_LEVEL) begin
            ld_reg       <= LD_WAIT;
            copy_idx_reg <= 8'h00;
        end else begin
            unique case (ld_reg)
                LD_WAIT: begin
                    ld_reg <= LD_COPY;
                end
                LD_COPY: begin
                    if (copy_idx_reg == CEE_LAST - CEE_FIRST) begin
                        ld_reg <= LD_READY;
                    end else begin
                        copy_idx_reg <= copy_idx_reg + 8'h01;
                    end
                end
                LD_READY: begin
                    if (stop_det && reboot_req_reg) begin
                        ld_reg       <= LD_COPY;
                        copy_idx_reg <= 8'h00;
                    end
                end
            endcase
        end
    end

    // EEPROM programming time starts when the writing frame ends
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ee_cnt_reg <= 16'h0000;
        end else if (stop_det && ee_wrote_reg) begin
            ee_cnt_reg <= 16'(EE_WR_CYCLES);
        end else if (ee_cnt_reg != 16'h0000) begin
            ee_cnt_reg <= ee_cnt_reg - 16'h0001;
        end
    end

    // outputs held low while supply is up but configuration not loaded
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            forced_reg <= 1'b0;
        end else begin
            forced_reg <= SUPPLY_ABOVE_1V && !loaded;
        end
    end

    // write latency: one pending update; a second write flushes the first early
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pend_reg       <= 1'b0;
            pend_addr_reg  <= 8'h00;
            eff_cnt_reg    <= 12'h000;
            CFG_APPLY_STB  <= 1'b0;
            CFG_APPLY_ADDR <= 8'h00;
            CFG_APPLY_DATA <= 8'h00;
        end else begin
            CFG_APPLY_STB <= 1'b0;
            if (cfg_wr) begin
                CFG_APPLY_STB  <= pend_reg;
                CFG_APPLY_ADDR <= pend_reg ? pend_addr_reg : CFG_APPLY_ADDR;
                CFG_APPLY_DATA <= pend_reg ? mem[pend_addr_reg] : CFG_APPLY_DATA;
                pend_reg       <= 1'b1;
                pend_addr_reg  <= ptr_reg;
                eff_cnt_reg    <= (ptr_reg <= THRESH_LAST_ADDR) ? EFFECT_THR_CYC - CNT_ONE
                                  : EFFECT_FAST_CYC - CNT_ONE;
            end else if (pend_reg && eff_cnt_reg == 12'h000) begin
                CFG_APPLY_STB  <= 1'b1;
                CFG_APPLY_ADDR <= pend_addr_reg;
                CFG_APPLY_DATA <= mem[pend_addr_reg];
                pend_reg       <= 1'b0;
            end else if (pend_reg) begin
                eff_cnt_reg <= eff_cnt_reg - CNT_ONE;
            end
        end
    end

    // open-drain data line: only ever pulled low
    assign SDA_OUT            = 1'b0;
    assign SDA_OE             = sda_oe_reg;
    assign OUTPUTS_FORCED_LOW = forced_reg;
    assign CONFIG_LOADED      = loaded;
    assign BUSY               = busy;

    ptr_step_a: assert property (@(posedge CLK) disable iff (RST)
        ld_data |=> ptr_reg == ptr_advance($past(ptr_reg)))
        else $error("pointer did not step after read");
    busy_nack_a: assert property (@(posedge CLK) disable iff (RST)
        (cmd_eval && busy) |=> (ph_reg == PH_HOLD && !SDA_OE && $stable(ptr_reg)))
        else $error("busy command was acknowledged or moved pointer");
    blk_count_a: assert property (@(posedge CLK) disable iff (RST)
        (scl_fall && ph_reg == PH_ACK_OUT && rw_reg && blk_armed_reg)
        |=> (shift_reg == BLK_RD_COUNT && blk_active_reg))
        else $error("block read did not open with count");
    blk_limit_a: assert property (@(posedge CLK) disable iff (RST)
        blk_cnt_reg <= BLK_MAX)
        else $error("block read went past sixteen bytes");
    nack_release_a: assert property (@(posedge CLK) disable iff (RST)
        (ph_reg == PH_ACK_IN && scl_rise && SDA_IN) |=> ##1 !SDA_OE)
        else $error("data line held after master refusal");
    cfg_sat_a: assert property (@(posedge CLK) disable iff (RST)
        (wr_evt && ptr_reg == CFG_LAST) |=> ptr_reg == CFG_LAST)
        else $error("pointer left read-only top");
    user_wrap_a: assert property (@(posedge CLK) disable iff (RST)
        ((ld_data || wr_evt) && ptr_reg == CEE_FIRST - 8'h01) |=> ptr_reg == CEE_FIRST)
        else $error("pointer did not run into config EEPROM");
    force_low_a: assert property (@(posedge CLK) disable iff (RST)
        (SUPPLY_ABOVE_1V && !loaded) |=> OUTPUTS_FORCED_LOW)
        else $error("outputs not forced low before load");
    load_time_a: assert property (@(posedge CLK) disable iff (RST)
        (ld_reg == LD_COPY && copy_idx_reg == 8'h00) |-> ##[1:40] ld_reg != LD_COPY)
        else $error("configuration load too slow");
    unload_nack_a: assert property (@(posedge CLK) disable iff (RST)
        (addr_eval && !loaded) |=> (!SDA_OE && ph_reg == PH_HOLD))
        else $error("access acknowledged before load");
    // the strobe rises 124 edges on and is sampled high one edge later
    fast_apply_a: assert property (@(posedge CLK) disable iff (RST)
        (cfg_wr && ptr_reg > THRESH_LAST_ADDR) |-> ##[1:125] CFG_APPLY_STB)
        else $error("register write took effect too late");

endmodule

// [tb/smbpc_master.sv]
// bus master model: drives the clock line and pulls data low through sda_low
module smbpc_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    // bus idles high
    initial begin
        scl = 1;
        sda_low = 0;
    end
    // third of a bit, three cycles, leaves room for the edge detector
    task automatic q;
        repeat (3) @(posedge clk);
        #5;
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic start;
        sda_low = 0;
        q;
        scl = 1;
        q;
        sda_low = 1;
        q;
        scl = 0;
        q;
    endtask
    // stop closes every transfer, refused ones too
    task automatic stop;
        sda_low = 1;
        q;
        scl = 1;
        q;
        sda_low = 0;
        q;
    endtask
    // nine slots msb first; a one releases the line so the device can answer
    task automatic bits(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_low = !d[i];
            q;
            scl = 1;
            q;
            r[i] = sda;
            scl = 0;
            q;
        end
    endtask
endmodule

// [tb/testbench.sv]
module testbench;
    import smbpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst, v1, vlo, oe, loaded, busy, forced, stb, scl, m_low, a, sdo, sel;
    logic [7:0] a_addr, a_data, d;
    logic [8:0] r9;
    int         errors = 0;
    int         num_checks = 0;
    // command byte beside its expected acknowledge
    logic [8:0] rows [8] = '{{8'h00, 1'b1}, {8'h2F, 1'b1}, {8'h30, 1'b0}, {8'h3F, 1'b0},
                            {8'h40, 1'b1}, {8'h9F, 1'b1}, {8'hA0, 1'b0}, {8'hC2, 1'b0}};
    // open drain wire with pull-up
    wire sda = !(m_low || (oe && !sdo));
    smbpc_serial_core DUT (.CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sdo),
        .SDA_OE(oe), .ADDRESS_SELECT_PIN(sel), .SUPPLY_ABOVE_1V(v1),
        .SUPPLY_ABOVE_LOCKOUT_LEVEL(vlo), .OUTPUTS_FORCED_LOW(forced),
        .CONFIG_LOADED(loaded), .BUSY(busy), .CFG_APPLY_STB(stb),
        .CFG_APPLY_ADDR(a_addr), .CFG_APPLY_DATA(a_data));
    smbpc_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // bounded wait, sampled between edges so registers have settled
    task automatic waitv(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) begin
            @(posedge clk);
            #5;
        end
    endtask
    task automatic wb(input logic [7:0] b, output logic k);
        logic [8:0] r;
        m.bits({b, 1'b1}, r);
        k = !r[0];
    endtask
    // address then command; the caller decides how the transfer ends
    task automatic cmd(input logic [7:0] c, output logic k);
        logic k0;
        m.start;
        wb(8'hA4, k0);
        wb(c, k);
    endtask
    // three reads, the last refused by the master
    task automatic rd3(input logic [7:0] e [3]);
        logic [8:0] r;
        foreach (e[i]) begin
            m.bits({8'hFF, i == 2}, r);
            chk("read data", e[i], r[8:1]);
        end
    endtask
    // preset, block write of three bytes, then probe while programming
    task automatic bw(input logic [7:0] p, input logic [7:0] x [3]);
        cmd(p, a);
        m.stop;
        cmd(CMD_BLK_WR, a);
        wb(8'h03, a);
        foreach (x[i]) wb(x[i], a);
        chk("write ack", 1, a);
        m.stop;
        cmd(8'h00, a);
        m.stop;
        chk("busy ack", 0, a);
        waitv(busy, 0, 1200);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: the run needs about a seventh of this span
    initial begin
        #3000000;
        errors++;
        give_verdict;
    end
    initial begin
        rst = 1;
        sel = 1;
        v1 = 0;
        vlo = 0;
        repeat (4) @(posedge clk);
        #5;
        rst = 0;
        v1 = 1;
        repeat (3) @(posedge clk);
        chk("forced low", 1, forced);
        m.start;
        wb(8'hA4, a);
        m.stop;
        chk("early ack", 0, a);
        vlo = 1;
        waitv(loaded, 1, 200);
        chk("loaded", 1, loaded);
        // forced release trails the load flag by one register
        @(posedge clk);
        #5;
        chk("forced low", 0, forced);
        $display("test power-up done");
        foreach (rows[i]) begin
            cmd(rows[i][8:1], a);
            m.stop;
            chk("command ack", rows[i][0], a);
        end
        // select pin must match address bit two
        m.start;
        wb(8'hA0, a);
        m.stop;
        chk("other address", 0, a);
        sel = 0;
        m.start;
        wb(8'hA0, a);
        m.stop;
        chk("select low", 1, a);
        sel = 1;
        $display("test command table done");
        bw(8'h7E, '{8'h11, 8'h22, 8'h33});
        bw(8'h9E, '{8'hAA, 8'hBB, 8'hCC});
        cmd(8'h7E, a);
        m.stop;
        cmd(CMD_BLK_RD, a);
        chk("block read ack", 1, a);
        m.start;
        wb(8'hA5, a);
        rd3('{BLK_RD_COUNT, 8'h11, 8'h22});
        repeat (12) @(posedge clk);
        #5;
        chk("line released", 0, oe);
        m.stop;
        // full block of sixteen, after which the device must stay silent
        cmd(USER_FIRST, a);
        m.stop;
        cmd(CMD_BLK_RD, a);
        m.start;
        wb(8'hA5, a);
        for (int i = 0; i < 18; i++) begin
            m.bits({8'hFF, i == 17}, r9);
            chk("block", i == 0 ? BLK_RD_COUNT : (i < 17) ? 8'h00 : 8'hFF, r9[8:1]);
        end
        m.stop;
        cmd(8'h9E, a);
        m.stop;
        m.start;
        wb(8'hA5, a);
        rd3('{8'hAA, 8'hCC, 8'hCC});
        m.stop;
        $display("test pointer done");
        cmd(8'h20, a);
        wb(8'h5A, a);
        m.stop;
        waitv(stb, 1, 200);
        chk("apply strobe", 1, stb);
        chk("apply addr", 8'h20, a_addr);
        chk("apply data", 8'h5A, a_data);
        // writes to the read-only top are dropped and the pointer holds
        cmd(CFG_LAST, a);
        wb(8'h5A, a);
        m.stop;
        m.start;
        wb(8'hA5, a);
        rd3('{8'h00, 8'h00, 8'h00});
        m.stop;
        cmd(8'h00, a);
        wb(8'h77, a);
        m.stop;
        cmd(CMD_REBOOT, a);
        m.stop;
        chk("reboot busy", 1, busy);
        waitv(busy, 0, 100);
        cmd(8'h00, a);
        m.stop;
        m.start;
        wb(8'hA5, a);
        rd3('{8'h33, 8'h00, 8'h00});
        m.stop;
        $display("test reboot done");
        give_verdict;
    end
endmodule
